// [gated_timer_pkg.sv]
// Purpose: Shared constants and types for the gated sixteen bit timer
// Assumes: Byte registers on a classic Wishbone bus, one aligned word each
// Notes:   Offsets are byte addresses; data sits in the low eight bits
package gated_timer_pkg;

  localparam int unsigned  AddrWidth = 5;
  localparam logic [4:0]   OffControl = 5'h00;
  localparam logic [4:0]   OffGate    = 5'h04;
  localparam logic [4:0]   OffLow     = 5'h08;
  localparam logic [4:0]   OffHigh    = 5'h0c;
  localparam logic [4:0]   OffOsc     = 5'h10;
  localparam logic [4:0]   OffStatus  = 5'h14;

  // Timer control field positions
  localparam int unsigned  CtlRunBit   = 0;
  localparam int unsigned  CtlSyncBit  = 2;
  localparam int unsigned  CtlSoscBit  = 3;
  localparam int unsigned  CtlPsLo     = 4;
  localparam int unsigned  CtlSrcBit   = 6;
  localparam int unsigned  CtlWideBit  = 7;
  // Gate control field positions
  localparam int unsigned  GateSsLo    = 0;
  localparam int unsigned  GatePolBit  = 6;
  localparam int unsigned  GateEnBit   = 7;
  // Oscillator control two field positions
  localparam int unsigned  OscScsLo    = 0;
  localparam int unsigned  OscForceBit = 3;
  localparam logic [1:0]   ScsSecOsc   = 2'h1;

  localparam logic [7:0]   ControlReset = 8'h00;
  localparam logic [7:0]   GateReset    = 8'h00;
  localparam logic [7:0]   OscReset     = 8'h00;
  localparam logic [15:0]  CountReset   = 16'h0000;

  typedef enum logic [1:0] {
    GatePin   = 2'b00,
    GateMatch = 2'b01,
    GateCmp1  = 2'b10,
    GateCmp2  = 2'b11
  } gate_src_e;

  // Control word as software writes it
  typedef struct packed {
    logic       wideAccessEnable;
    logic       externalSource;
    logic [1:0] prescaleSelect;
    logic       timerSecoscEnable;
    logic       syncBypass;
    logic       reserved;
    logic       timerRun;
  } control_s;

  typedef struct packed {
    logic       gateEnableBit;
    logic       gatePolarityBit;
    logic [3:0] reserved;
    gate_src_e  gateSourceSelect;
  } gate_s;

endpackage

// [sync_two_ff.sv]
// Purpose: Two flip-flop synchroniser for a level
// Assumes: Input is asynchronous to clk
// Notes:   The first stage is read only by the second stage
`timescale 1ns/100ps
module sync_two_ff
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);

  logic stage1_q;

  // Metastability settles in the first stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_q <= 1'b0;
      dout     <= 1'b0;
    end
    else
    begin
      stage1_q <= din;
      dout     <= stage1_q;
    end
  end

endmodule

// [prescale_counter.sv]
// Purpose: Divide count ticks by 1, 2, 4 or 8
// Assumes: tick is a one-cycle pulse on clk
// Notes:   clear wins over a tick in the same cycle
`timescale 1ns/100ps
module prescale_counter
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  output logic            pulse
);

  logic [2:0] count_q;
  logic [2:0] mask;

  // Ratio 2**ratio needs ratio low bits all ones before the output fires
  assign mask = 3'((4'h1 << ratio) - 4'h1);
  assign pulse = tick && ((count_q & mask) == mask);

  // Counter is hidden from software; only a clear touches it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_q <= 3'h0;
    else if (clear)
      count_q <= 3'h0;
    else if (tick)
      count_q <= 3'(count_q + 3'h1);
  end

endmodule

// [gated_sixteen_bit_timer.sv]
// Purpose: Sixteen bit timer with prescaler, gate and wide access mode
// Assumes: Classic Wishbone slave, one clock; external inputs are pins
// Notes:   Asynchronous count clock is modelled as a sampled edge stream
// Function
// - Selected count clock divided by 1, 2, 4 or 8 per prescale field.
// - Prescaler hidden; outside wide mode any count byte write clears it.
// - In wide mode a high write keeps prescaler; low write clears it.
// - Oscillator enabled by timer bit, force bit, or clock select 01.
// - Bypass bit passes external clock without phase synchronisation.
// - Async external mode counts in sleep; overflow can wake processor.
// - Mode switch may skip or add one increment.
// - Reads of either byte stay valid while counting externally.
// - Wide bit enables 16-bit mode through a high byte buffer.
// - Wide mode low read latches high byte; high read returns buffer.
// - Software preloads buffer; low write loads both halves at once.
// - Gate enable bit turns gating on; polarity bit picks level.
// - Permitted gate counts on clock rising edges; blocked gate holds.
// - Without gate control the counter counts freely.
// - Gate source: pin, period match, comparator 1, comparator 2.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module gated_sixteen_bit_timer
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        extClockPin,
  input  wire logic        gatePin,
  input  wire logic        periodMatch,
  input  wire logic        comparatorOne,
  input  wire logic        comparatorTwo,
  input  wire logic        sleepMode,
  output logic             secoscEnable,
  output logic             overflowPulse,
  output logic             wakeRequest,
  output logic [15:0]      countValue
);

  gated_timer_pkg::control_s control_q;
  gated_timer_pkg::gate_s    gate_q;
  logic [7:0]                oscControl_q;
  logic [15:0]               count_q;
  logic [7:0]                highBuffer_q;
  logic                      overflowFlag_q;
  logic [31:0]               readData_d;

  logic extSync;
  logic extAsyncIn_q;
  logic extPrev_q;
  logic extPrevAsync_q;
  logic extAsyncMid_q;
  logic gatePinSync;
  logic cmpOneSync;
  logic cmpTwoSync;
  logic extRise;
  logic internalTick;
  logic selTick;
  logic presPulse;
  logic gateLevel;
  logic gateOpen;
  logic countStep;
  logic access;
  logic writeLane;
  logic writeLow;
  logic writeHigh;
  logic readLow;
  logic presClear;
  logic wide;
  logic clrOverflow;
  logic countWrite;
  logic wrapStep;

  // Pins cross two flip-flops before any logic reads them
  sync_two_ff uSyncExt
  (
    .clk  (clk),
    .rst  (rst),
    .din  (extClockPin),
    .dout (extSync)
  );

  sync_two_ff uSyncGate
  (
    .clk  (clk),
    .rst  (rst),
    .din  (gatePin),
    .dout (gatePinSync)
  );

  sync_two_ff uSyncCmp1
  (
    .clk  (clk),
    .rst  (rst),
    .din  (comparatorOne),
    .dout (cmpOneSync)
  );

  sync_two_ff uSyncCmp2
  (
    .clk  (clk),
    .rst  (rst),
    .din  (comparatorTwo),
    .dout (cmpTwoSync)
  );

  // Bypass path keeps its own two capture stages apart from the phase
  // synchroniser, so a metastable pin never reaches the edge logic
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      extAsyncIn_q   <= 1'b0;
      extAsyncMid_q  <= 1'b0;
      extPrevAsync_q <= 1'b0;
      extPrev_q      <= 1'b0;
    end
    else
    begin
      extAsyncIn_q   <= extClockPin;
      extAsyncMid_q  <= extAsyncIn_q;
      extPrevAsync_q <= extAsyncMid_q;
      extPrev_q      <= extSync;
    end
  end

  // Switching paths may drop or repeat one edge; accepted behaviour
  assign extRise = control_q.syncBypass
                 ? (extAsyncMid_q && !extPrevAsync_q)
                 : (extSync && !extPrev_q);
  assign internalTick = 1'b1;

  // Source select: internal instruction tick or external pin edges
  assign selTick = control_q.externalSource ? extRise : internalTick;

  // Sleep stops the internal clock path; external bypass keeps running
  logic runAllowed;
  assign runAllowed = control_q.timerRun
                   && (!sleepMode
                       || (control_q.externalSource
                           && control_q.syncBypass));

  // Gate source selection and polarity compare
  always_comb
  begin
    case (gate_q.gateSourceSelect)
      gated_timer_pkg::GatePin:   gateLevel = gatePinSync;
      gated_timer_pkg::GateMatch: gateLevel = periodMatch;
      gated_timer_pkg::GateCmp1:  gateLevel = cmpOneSync;
      gated_timer_pkg::GateCmp2:  gateLevel = cmpTwoSync;
      default:                    gateLevel = 1'b0;
    endcase
  end

  // Ungated timer counts freely; gated one only at the chosen level
  assign gateOpen = !gate_q.gateEnableBit
                 || (gateLevel == gate_q.gatePolarityBit);

  // Bus decode; only lane 0 carries data for these byte registers
  assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign writeLane = access && wb_we_i && wb_sel_i[0];
  assign wide      = control_q.wideAccessEnable;
  assign writeLow  = writeLane && (wb_adr_i == gated_timer_pkg::OffLow);
  assign writeHigh = writeLane && (wb_adr_i == gated_timer_pkg::OffHigh);
  assign readLow   = access && !wb_we_i
                  && (wb_adr_i == gated_timer_pkg::OffLow);
  assign clrOverflow = writeLane
                    && (wb_adr_i == gated_timer_pkg::OffStatus)
                    && wb_dat_i[0];

  // Prescaler clear: both byte writes outside wide mode, low only inside
  assign presClear = writeLow
                  || (writeHigh && !wide);

  prescale_counter uPrescale
  (
    .clk   (clk),
    .rst   (rst),
    .tick  (selTick && runAllowed && gateOpen),
    .clear (presClear),
    .ratio (control_q.prescaleSelect),
    .pulse (presPulse)
  );

  assign countStep = presPulse;

  // A count byte write wins over a step, so it also suppresses the wrap
  assign countWrite = writeLow || (writeHigh && !wide);
  assign wrapStep   = countStep && (count_q == 16'hffff) && !countWrite;

  // Control registers written by software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_q    <= gated_timer_pkg::ControlReset;
      gate_q       <= gated_timer_pkg::GateReset;
      oscControl_q <= gated_timer_pkg::OscReset;
    end
    else if (writeLane)
    begin
      if (wb_adr_i == gated_timer_pkg::OffControl)
        control_q <= wb_dat_i[7:0];
      if (wb_adr_i == gated_timer_pkg::OffGate)
        gate_q <= wb_dat_i[7:0];
      if (wb_adr_i == gated_timer_pkg::OffOsc)
        oscControl_q <= wb_dat_i[7:0];
    end
  end

  // Counter: a write wins over a step, so software need not stop it first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_q <= gated_timer_pkg::CountReset;
    else if (writeLow && wide)
      count_q <= {highBuffer_q, wb_dat_i[7:0]};
    else if (writeLow)
      count_q <= {count_q[15:8], wb_dat_i[7:0]};
    else if (writeHigh && !wide)
      count_q <= {wb_dat_i[7:0], count_q[7:0]};
    else if (countStep)
      count_q <= 16'(count_q + 16'h0001);
  end

  // High byte buffer: preload by high write, latch on low read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      highBuffer_q <= 8'h00;
    else if (readLow && wide)
      highBuffer_q <= count_q[15:8];
    else if (writeHigh && wide)
      highBuffer_q <= wb_dat_i[7:0];
  end

  // Overflow flag: a wrap in the clearing cycle keeps the flag set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      overflowFlag_q <= 1'b0;
    else if (wrapStep)
      overflowFlag_q <= 1'b1;
    else if (clrOverflow)
      overflowFlag_q <= 1'b0;
  end

  // Read mux; the count is held in clk flops so reads never tear
  always_comb
  begin
    readData_d = 32'h0000_0000;
    case (wb_adr_i)
      gated_timer_pkg::OffControl: readData_d[7:0] = control_q;
      gated_timer_pkg::OffGate:    readData_d[7:0] = gate_q;
      gated_timer_pkg::OffLow:     readData_d[7:0] = count_q[7:0];
      gated_timer_pkg::OffHigh:
        readData_d[7:0] = wide ? highBuffer_q : count_q[15:8];
      gated_timer_pkg::OffOsc:     readData_d[7:0] = oscControl_q;
      gated_timer_pkg::OffStatus:  readData_d[0]   = overflowFlag_q;
      default:                     readData_d = 32'h0000_0000;
    endcase
  end

  // Single wait-free answer: ack one cycle after the strobe, then drop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= access;
      wb_dat_o <= access ? readData_d : 32'h0000_0000;
    end
  end

  // Oscillator request: any one of three enables keeps it running,
  // and nothing here drops it in sleep
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      secoscEnable <= 1'b0;
    else
      secoscEnable <= control_q.timerSecoscEnable
                   || oscControl_q[gated_timer_pkg::OscForceBit]
                   || (oscControl_q[gated_timer_pkg::OscScsLo +: 2]
                       == gated_timer_pkg::ScsSecOsc);
  end

  // Event pulses; wake only for a wrap that lands while asleep
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      overflowPulse <= 1'b0;
      wakeRequest   <= 1'b0;
    end
    else
    begin
      overflowPulse <= wrapStep;
      wakeRequest   <= sleepMode && wrapStep;
    end
  end

  // Count copy for the chip; one cycle behind the counter itself
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      countValue <= gated_timer_pkg::CountReset;
    else
      countValue <= count_q;
  end

  // Elaboration checks: decode and byte lanes rely on these values
  if (gated_timer_pkg::AddrWidth != 5)
  begin : gAddrWidth
    $error("Register address must be five bits wide");
  end

  if ($bits(gated_timer_pkg::control_s) != 8
      || $bits(gated_timer_pkg::gate_s) != 8)
  begin : gByteWords
    $error("Control and gate words must be one byte each");
  end

  if (gated_timer_pkg::OscForceBit > 7 || gated_timer_pkg::OscScsLo > 6)
  begin : gOscFields
    $error("Oscillator fields must lie within one byte");
  end

endmodule

// [gated_timer_checker.sv]
// Purpose: Port level checker for the gated sixteen bit timer
// Assumes: Sees only the top module ports; one clock domain
// Notes:   Bound to every instance of the timer below
`timescale 1ns/100ps
module gated_timer_checker
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sleepMode,
  input wire logic        overflowPulse,
  input wire logic        wakeRequest,
  input wire logic [15:0] countValue
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus answer timing and read data framing
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  chk_dat_idle: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  chk_dat_upper: assert property (
    wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  // The counter only steps by one unless software wrote it
  chk_count_step: assert property (
    countValue != $past(countValue) &&
    countValue != $past(countValue) + 16'h1
    |-> $past(wb_we_i && wb_ack_o)) else $error("count jump");
  // Overflow marks the all ones to zero wrap only
  chk_ovf_wrap: assert property (
    overflowPulse |-> countValue == 16'hffff ##1 countValue == 16'h0000)
    else $error("overflow off wrap");
  chk_ovf_pulse: assert property (
    overflowPulse |=> !overflowPulse) else $error("overflow held");
  // Wake needs an overflow seen during sleep
  chk_wake_sleep: assert property (
    wakeRequest |-> overflowPulse && ($past(sleepMode) || sleepMode))
    else $error("wake outside sleep");
  cov_wake: cover property (wakeRequest);
  cov_ovf: cover property (overflowPulse);
  cov_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind gated_sixteen_bit_timer gated_timer_checker gated_timer_checker_i (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sleepMode(sleepMode), .overflowPulse(overflowPulse),
  .wakeRequest(wakeRequest), .countValue(countValue));

// [gated_sixteen_bit_timer_tb.sv]
// Purpose: Self checking bench for the gated sixteen bit timer
// Assumes: Wishbone ack arrives one edge after a request is taken
// Notes:   Expected values are written into each check here, as constants or as values the bench saved earlier
`timescale 1ns/100ps
module gated_sixteen_bit_timer_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [4:0]  wbAdr = 5'h0;
  logic [31:0] wbDin = 32'h0;
  logic [3:0]  wbSel = 4'h1;
  logic [31:0] wbDout;
  logic        wbAck;
  logic        ext = 1'b0;
  logic [3:0]  gsrc = 4'h0;
  logic        sleepMode = 1'b0;
  logic        secosc;
  logic        ovf;
  logic        wake;
  logic        sawWake = 1'b0;
  logic [15:0] countValue;
  int          errors = 0;
  int          nChecks = 0;

  gated_sixteen_bit_timer gated_sixteen_bit_timer_i (
    .clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDin),
    .wb_sel_i(wbSel), .wb_dat_o(wbDout), .wb_ack_o(wbAck),
    .extClockPin(ext), .gatePin(gsrc[0]), .periodMatch(gsrc[1]),
    .comparatorOne(gsrc[2]), .comparatorTwo(gsrc[3]),
    .sleepMode(sleepMode), .secoscEnable(secosc), .overflowPulse(ovf),
    .wakeRequest(wake), .countValue(countValue));

  // Free running bus clock
  always #25 clk = ~clk;
  // Wake is a one cycle pulse, so latch it for later comparison
  always @(posedge clk)
    if (wake === 1'b1) sawWake <= 1'b1;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nChecks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic we, input logic [4:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDin <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbDout[7:0];
    if (n >= 20)
    begin
      errors++;
      tally_and_finish();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h0, q);
    chk(q, e);
  endtask

  // Cycles until the count moves; bounded so a stuck count fails
  task automatic waitChg(output int g);
    logic [15:0] c;
    c = countValue;
    g = 0;
    do
    begin
      @(posedge clk);
      g++;
    end while (countValue === c && g < 40);
    if (g >= 40)
    begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic pins(input int k);
    repeat (k)
    begin
      ext <= 1'b1;
      repeat (3) @(posedge clk);
      ext <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // Address, data, expected oscillator enable
  logic [13:0] osc [6] = '{{5'h00, 8'h08, 1'b1}, {5'h00, 8'h00, 1'b0},
    {5'h10, 8'h08, 1'b1}, {5'h10, 8'h01, 1'b1},
    {5'h10, 8'h02, 1'b0}, {5'h10, 8'h00, 1'b0}};

  initial
  begin
    int g;
    logic [15:0] v;
    logic [3:0] r;
    void'($urandom(86719));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(5'h18, 8'hff);
    for (int i = 0; i < 7; i++)
      rd(5'(i * 4), 8'h0);
    // A write without lane 0 is ignored but still answered
    wbSel <= 4'he;
    wr(5'h04, 8'hff);
    wbSel <= 4'h1;
    rd(5'h04, 8'h00);
    foreach (osc[i])
    begin
      wr(osc[i][13:9], osc[i][8:1]);
      repeat (2) @(posedge clk);
      chk(secosc, osc[i][0]);
    end
    // Free running internal count at each prescale ratio
    for (int p = 0; p < 4; p++)
    begin
      wr(5'h00, 8'(8'h01 | (p << 4)));
      waitChg(g);
      waitChg(g);
      chk(g, 1 << p);
    end
    // Right after a step at /8: cleared prescaler needs 8, untouched 5
    wr(5'h08, 8'h00);
    waitChg(g);
    chk(g, 8);
    wr(5'h0c, 8'h00);
    waitChg(g);
    chk(g, 8);
    wr(5'h00, 8'hb1);
    waitChg(g);
    wr(5'h0c, 8'h12);
    waitChg(g);
    chk(g, 5);
    wr(5'h08, 8'h34);
    waitChg(g);
    chk(g, 8);
    // Gate on every source and polarity: blocked holds, open counts
    for (int s = 0; s < 8; s++)
    begin
      wr(5'h04, 8'(8'h80 | ((s & 1) << 6) | (s >> 1)));
      for (int open = 0; open < 2; open++)
      begin
        r = 4'($urandom);
        r[s >> 1] = open[0] ~^ s[0];
        gsrc <= r;
        repeat (5) @(posedge clk);
        v = countValue;
        repeat (8) @(posedge clk);
        if (open == 1)
          chk(countValue !== v, 1'b1);
        else
          chk(countValue, v);
      end
    end
    wr(5'h04, 8'h00);
    // Wide access through the high byte buffer
    wr(5'h00, 8'h80);
    v = 16'($urandom);
    wr(5'h0c, v[15:8]);
    wr(5'h08, v[7:0]);
    repeat (2) @(posedge clk);
    chk(countValue, v);
    wr(5'h0c, ~v[15:8]);
    repeat (2) @(posedge clk);
    chk(countValue, v);
    rd(5'h0c, ~v[15:8]);
    rd(5'h08, v[7:0]);
    rd(5'h0c, v[15:8]);
    // Internal wrap raises the sticky overflow flag
    wr(5'h00, 8'h00);
    wr(5'h08, 8'hfd);
    wr(5'h0c, 8'hff);
    wr(5'h00, 8'h01);
    g = 0;
    do
    begin
      @(posedge clk);
      g++;
    end while (ovf !== 1'b1 && g < 30);
    chk(g < 30, 1'b1);
    if (g >= 30)
      tally_and_finish();
    rd(5'h14, 8'h01);
    wr(5'h14, 8'h01);
    rd(5'h14, 8'h00);
    // External pin counting, synchronised then bypassed
    for (int m = 0; m < 2; m++)
    begin
      wr(5'h00, 8'(8'h40 | (m << 2)));
      wr(5'h08, 8'h00);
      wr(5'h0c, 8'h00);
      wr(5'h00, 8'(8'h41 | (m << 2)));
      pins(5);
      repeat (6) @(posedge clk);
      chk(countValue, 16'h5);
      rd(5'h08, 8'h05);
      rd(5'h0c, 8'h00);
    end
    // Bypassed external count keeps running in sleep and wakes
    wr(5'h00, 8'h44);
    wr(5'h08, 8'hfc);
    wr(5'h0c, 8'hff);
    wr(5'h00, 8'h45);
    sleepMode <= 1'b1;
    pins(6);
    chk(sawWake, 1'b1);
    chk(countValue, 16'(16'hfffc + 16'h0006));
    // Phase synchronised external path stops in sleep
    wr(5'h00, 8'h41);
    pins(2);
    chk(countValue, 16'h0002);
    sleepMode <= 1'b0;
    tally_and_finish();
  end
endmodule
